// ### rtl/nipc_regs.svh
/*
  Constants for the nested interrupt priority controller: in-service
  register bit positions, reset values and default counts.
  Assumes inclusion by bare name from any design file.
*/
`ifndef NIPC_REGS_SVH
`define NIPC_REGS_SVH

// ----------------------------------------------------------------
// in-service register layout
// ----------------------------------------------------------------
`define NIPC_ISR_W 8
`define NIPC_ISR_NMI_BIT 6
`define NIPC_ISR_RST 8'h00

// ----------------------------------------------------------------
// source and counter defaults
// ----------------------------------------------------------------
`define NIPC_NUM_SRC 19
`define NIPC_CNT_W 16
`define NIPC_LVL_W 2

`endif

// ### rtl/nipc_pkg.sv
/*
  Types for the nested interrupt priority controller.
  Assumes nipc_regs.svh constants are available.
*/
`include "nipc_regs.svh"

package nipc_pkg;
  typedef logic [`NIPC_LVL_W-1:0] nipc_lvl_t;
  typedef enum logic [1:0] {
    NIPC_ACK_NONE,
    NIPC_ACK_VEC,
    NIPC_ACK_MACRO,
    NIPC_ACK_NMI
  } nipc_ack_e;
endpackage

// ### rtl/nipc_ctrl.sv
/*
  Nested interrupt priority controller: picks which maskable request,
  macro service request or non-maskable request the core takes next,
  keeps the in-service register and macro service counters.
  Assumes request and mask bits are synchronous to ref_clk_i and that
  the core sequencer acts on ack_o in the cycle it is pulsed.
*/
`timescale 1ns/1ps
`include "nipc_regs.svh"

module nipc_ctrl #(
  parameter int NUM_SRC = `NIPC_NUM_SRC,
  parameter int CNT_W = `NIPC_CNT_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [NUM_SRC-1:0] irq_req_i,
  input wire logic [NUM_SRC-1:0] irq_mask_i,
  input wire logic [NUM_SRC-1:0] macro_en_i,
  input wire logic [2*NUM_SRC-1:0] prio_lvl_i,
  input wire logic nmi_req_i,
  input wire logic level3_nest_select_i,
  input wire logic ei_set_i,
  input wire logic di_set_i,
  input wire logic reti_i,
  input wire logic cnt_load_i,
  input wire logic [CNT_W-1:0] cnt_load_val_i,
  input wire logic [$clog2(NUM_SRC)-1:0] cnt_load_sel_i,
  output nipc_pkg::nipc_ack_e ack_kind_o,
  output logic ack_o,
  output logic [$clog2(NUM_SRC)-1:0] ack_src_o,
  output logic [NUM_SRC-1:0] req_clr_o,
  output logic global_irq_enable_flag_o,
  output logic [`NIPC_ISR_W-1:0] in_service_level_reg_o
);
  import nipc_pkg::*;

  localparam int SW = $clog2(NUM_SRC);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [`NIPC_ISR_W-1:0] isr_ff, nxt_isr;
  logic en_ff, nxt_en;
  logic [CNT_W-1:0] cnt_ff [NUM_SRC];
  logic [CNT_W-1:0] nxt_cnt [NUM_SRC];
  logic [NUM_SRC-1:0] vec_due_ff, nxt_vec_due;
  nipc_ack_e kind_ff, nxt_kind;
  logic [SW-1:0] src_ff, nxt_src;
  logic [NUM_SRC-1:0] clr_ff, nxt_clr;

  // the NMI bit, else the lowest set bit of bits 0 to 3 of the in-service register, is the active level
  function automatic logic [2:0] svc_level(input logic [`NIPC_ISR_W-1:0] v);
    svc_level = 3'h4;
    if (v[`NIPC_ISR_NMI_BIT]) begin
      svc_level = 3'h5;
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (v[i]) begin
          svc_level = 3'(i);
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [2:0] cur_lvl;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] vec_ok;
  logic mac_hit, vec_hit;
  logic [SW-1:0] mac_idx, vec_idx;
  logic [1:0] vec_lvl;

  assign cur_lvl = svc_level(isr_ff);

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      logic [1:0] lv;
      assign lv = prio_lvl_i[2*g +: 2];
      assign pend[g] = irq_req_i[g] & ~irq_mask_i[g];
      // level-3 nests only over level 3 when nest select is clear
      // a source whose macro count ran out competes as a vectored one
      assign vec_ok[g] = pend[g] & (~macro_en_i[g] | vec_due_ff[g]) & en_ff &
        ((cur_lvl == 3'h4) |
         ((cur_lvl == 3'h3) & (~level3_nest_select_i | (lv != 2'h3))) |
         ((cur_lvl == 3'h2) & (lv < 2'h2)) |
         ((cur_lvl == 3'h1) & (lv == 2'h0)));
    end
  endgenerate

  always_comb begin
    mac_hit = 1'b0;
    mac_idx = '0;
    vec_hit = 1'b0;
    vec_idx = '0;
    vec_lvl = 2'h3;
    // macro service is not gated by enable or in-service level
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] & macro_en_i[i] & ~vec_due_ff[i]) begin
        mac_hit = 1'b1;
        mac_idx = SW'(i);
      end
    end
    // descending scan with <= keeps the lowest index on ties
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (vec_ok[i] && (!vec_hit || prio_lvl_i[2*i +: 2] <= vec_lvl)) begin
        vec_hit = 1'b1;
        vec_idx = SW'(i);
        vec_lvl = prio_lvl_i[2*i +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_isr = isr_ff;
    nxt_en = en_ff;
    nxt_cnt = cnt_ff;
    nxt_vec_due = vec_due_ff;
    nxt_kind = NIPC_ACK_NONE;
    nxt_src = '0;
    nxt_clr = '0;
    if (ei_set_i) begin
      nxt_en = 1'b1;
    end
    if (di_set_i) begin
      nxt_en = 1'b0;
    end
    if (reti_i) begin
      // clear the highest-priority in-service bit on return
      case (cur_lvl)
        3'h5: nxt_isr[`NIPC_ISR_NMI_BIT] = 1'b0;
        3'h0, 3'h1, 3'h2, 3'h3: nxt_isr[cur_lvl[1:0]] = 1'b0;
        default: nxt_isr = isr_ff;
      endcase
    end
    if (cnt_load_i) begin
      nxt_cnt[cnt_load_sel_i] = cnt_load_val_i;
      nxt_vec_due[cnt_load_sel_i] = 1'b0;
    end
    if (nmi_req_i && cur_lvl != 3'h5) begin
      nxt_kind = NIPC_ACK_NMI;
      nxt_en = 1'b0;
      nxt_isr[`NIPC_ISR_NMI_BIT] = 1'b1;
    end else if (mac_hit) begin
      // transfer only: no enable change, no in-service bit
      nxt_kind = NIPC_ACK_MACRO;
      nxt_src = mac_idx;
      nxt_clr[mac_idx] = 1'b1;
      nxt_cnt[mac_idx] = cnt_ff[mac_idx] - CNT_W'(1);
      if (cnt_ff[mac_idx] == CNT_W'(1)) begin
        // keep request alive so the vectored entry follows
        nxt_vec_due[mac_idx] = 1'b1;
        nxt_clr[mac_idx] = 1'b0;
      end
    end else if (vec_hit) begin
      nxt_kind = NIPC_ACK_VEC;
      nxt_src = vec_idx;
      nxt_clr[vec_idx] = 1'b1;
      nxt_en = 1'b0;
      nxt_isr[vec_lvl] = 1'b1;
      nxt_vec_due[vec_idx] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      isr_ff <= `NIPC_ISR_RST;
      en_ff <= 1'b0;
      cnt_ff <= '{default: '0};
      vec_due_ff <= '0;
      kind_ff <= NIPC_ACK_NONE;
      src_ff <= '0;
      clr_ff <= '0;
    end else begin
      isr_ff <= nxt_isr;
      en_ff <= nxt_en;
      cnt_ff <= nxt_cnt;
      vec_due_ff <= nxt_vec_due;
      kind_ff <= nxt_kind;
      src_ff <= nxt_src;
      clr_ff <= nxt_clr;
    end
  end

  assign ack_kind_o = kind_ff;
  assign ack_o = (kind_ff != NIPC_ACK_NONE);
  assign ack_src_o = src_ff;
  assign req_clr_o = clr_ff;
  assign global_irq_enable_flag_o = en_ff;
  assign in_service_level_reg_o = isr_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_vec_clears_en: assert property ((nxt_kind == NIPC_ACK_VEC) |=> !en_ff)
    else $error("enable flag not cleared on vectored accept");
  a_nmi_sets_bit: assert property ((nxt_kind == NIPC_ACK_NMI)
    |=> isr_ff[`NIPC_ISR_NMI_BIT] && !en_ff)
    else $error("nmi in-service bit not set");
  a_vec_needs_en: assert property ((nxt_kind == NIPC_ACK_VEC) |-> en_ff)
    else $error("vectored accept with enable low");
  a_lvl1_only0: assert property ((nxt_kind == NIPC_ACK_VEC && cur_lvl == 3'h1)
    |-> vec_lvl == 2'h0)
    else $error("level 1 in service admitted level above 0");
  a_lvl2_only01: assert property ((nxt_kind == NIPC_ACK_VEC && cur_lvl == 3'h2)
    |-> vec_lvl < 2'h2)
    else $error("level 2 in service admitted level 2 or 3");
  a_lvl3_select: assert property ((nxt_kind == NIPC_ACK_VEC && cur_lvl == 3'h3 &&
    level3_nest_select_i) |-> vec_lvl != 2'h3)
    else $error("level 3 nesting ignored select");
  a_lvl0_macro: assert property ((cur_lvl == 3'h0 || cur_lvl == 3'h5)
    |-> nxt_kind != NIPC_ACK_VEC)
    else $error("vectored accept during level 0 or nmi");
  a_isr_level_set: assert property ((nxt_kind == NIPC_ACK_VEC)
    |=> isr_ff[$past(vec_lvl)])
    else $error("in-service bit for level not set");
  // a return in the same cycle may clear a bit, so only new bits are checked
  a_macro_keeps: assert property ((nxt_kind == NIPC_ACK_MACRO)
    |=> ((isr_ff & ~$past(isr_ff)) == '0) &&
        (en_ff == (($past(en_ff) | $past(ei_set_i)) & ~$past(di_set_i))))
    else $error("macro service touched in-service state");
  a_pend_masked: assert property ((nxt_kind == NIPC_ACK_VEC)
    |-> irq_req_i[nxt_src] && !irq_mask_i[nxt_src])
    else $error("accepted a masked or idle source");

  c_nest: cover property (en_ff && cur_lvl == 3'h3 && nxt_kind == NIPC_ACK_VEC);
  c_macro_end: cover property (nxt_kind == NIPC_ACK_MACRO && nxt_vec_due[nxt_src]);
  c_nmi: cover property (nxt_kind == NIPC_ACK_NMI);
  c_macro_en_low: cover property (!en_ff && nxt_kind == NIPC_ACK_MACRO);
endmodule

// ### verif/nipc_src_model.sv
/*
  Peripheral request sources facing the controller: one flag per source.
  Assumes set pulses from the bench and req_clr_o from the controller.
*/
`timescale 1ns/1ps
module nipc_src_model #(
  parameter int NUM_SRC = 19
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [NUM_SRC-1:0] set_i,
  input wire logic [NUM_SRC-1:0] clr_i,
  output logic [NUM_SRC-1:0] req_o
);
  logic [NUM_SRC-1:0] req_ff;
  // drop at once on clear, else a macro request would be taken twice
  assign req_o = req_ff & ~clr_i;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_ff <= '0;
    end else begin
      req_ff <= (req_ff & ~clr_i) | set_i;
    end
  end
endmodule

// ### verif/nipc_ctrl_tb.sv
/*
  Self-checking bench for the nested interrupt priority controller.
  Assumes nipc_pkg and the request source model are compiled first.
*/
`timescale 1ns/1ps
module nipc_ctrl_tb;
  import nipc_pkg::*;
  logic clk = 0, rst = 1, nmi = 0, nest = 0, ei = 0, reti = 0, ld = 0;
  logic [18:0] set_v = '0, mask = '0, men = '0, req, clr;
  logic [37:0] lv = '0;
  nipc_ack_e kind;
  logic ack, en;
  logic [4:0] src;
  logic [7:0] isr;
  int errors = 0, check_count = 0;
  always #4 clk = ~clk;
  nipc_src_model srcs (.ref_clk_i(clk), .rst_i(rst), .set_i(set_v), .clr_i(clr), .req_o(req));
  nipc_ctrl uut (.ref_clk_i(clk), .rst_i(rst), .irq_req_i(req), .irq_mask_i(mask),
    .macro_en_i(men), .prio_lvl_i(lv), .nmi_req_i(nmi), .level3_nest_select_i(nest),
    .ei_set_i(ei), .di_set_i(1'b0), .reti_i(reti), .cnt_load_i(ld),
    .cnt_load_val_i(16'h0002), .cnt_load_sel_i(5'h09), .ack_kind_o(kind), .ack_o(ack),
    .ack_src_o(src), .req_clr_o(clr), .global_irq_enable_flag_o(en),
    .in_service_level_reg_o(isr));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rs;
    rst = 1;
    tick(20);
    rst = 0;
  endtask
  task automatic raise(input logic [18:0] v);
    set_v = v;
    tick(1);
    set_v = '0;
  endtask
  // w: 0 load count, 1 enable flag, 2 return
  // each pulse touches only its own strobe, so back to back calls never
  // assign one signal twice at the same edge
  task automatic pls(input int w);
    case (w)
      0: ld = 1'b1;
      1: ei = 1'b1;
      default: reti = 1'b1;
    endcase
    tick(1);
    case (w)
      0: ld = 1'b0;
      1: ei = 1'b0;
      default: reti = 1'b0;
    endcase
  endtask
  // bounded wait, the answer is due one cycle after the request is taken
  task automatic ackw(input logic [1:0] k, input logic [4:0] s);
    int n = 0;
    while (ack !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    chk("ack", 1, ack);
    chk("kind", k, kind);
    chk("src", s, src);
    if (k == NIPC_ACK_VEC) begin
      chk("clr", 1, clr[s]);
    end
    tick(1);
  endtask
  task automatic none;
    repeat (4) begin
      tick(1);
      chk("idle", 0, ack);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_nest;
    lv = '0;
    lv[7:6] = 2'h1;
    lv[5:4] = 2'h2;
    rs;
    pls(1);
    raise(19'h00008);
    ackw(NIPC_ACK_VEC, 5'h03);
    chk("enable", 0, en);
    chk("isr", 8'h02, isr);
    pls(1);
    raise(19'h00004);
    none;
    raise(19'h00001);
    ackw(NIPC_ACK_VEC, 5'h00);
    chk("isr", 8'h03, isr);
    pls(2);
    pls(1);
    none;
    pls(2);
    pls(1);
    ackw(NIPC_ACK_VEC, 5'h02);
    chk("isr", 8'h04, isr);
  endtask
  task automatic t_order;
    lv = '0;
    lv[3:2] = 2'h1;
    lv[9:8] = 2'h2;
    lv[15:14] = 2'h2;
    mask = 19'h00020;
    rs;
    pls(1);
    raise(19'h00022);
    ackw(NIPC_ACK_VEC, 5'h01);
    mask = '0;
    pls(2);
    pls(1);
    ackw(NIPC_ACK_VEC, 5'h05);
    pls(2);
    pls(1);
    raise(19'h00090);
    ackw(NIPC_ACK_VEC, 5'h04);
    pls(2);
    pls(1);
    ackw(NIPC_ACK_VEC, 5'h07);
  endtask
  task automatic t_lvl3;
    lv = '0;
    lv[17:16] = 2'h3;
    lv[13:12] = 2'h3;
    nest = 1;
    rs;
    pls(1);
    raise(19'h00100);
    ackw(NIPC_ACK_VEC, 5'h08);
    chk("isr", 8'h08, isr);
    pls(1);
    raise(19'h00040);
    none;
    nest = 0;
    ackw(NIPC_ACK_VEC, 5'h06);
    nest = 1;
  endtask
  task automatic t_macro;
    lv = '0;
    men = 19'h00200;
    rs;
    pls(0);
    raise(19'h00200);
    ackw(NIPC_ACK_MACRO, 5'h09);
    chk("isr", 8'h00, isr);
    raise(19'h00204);
    ackw(NIPC_ACK_MACRO, 5'h09);
    none;
    pls(1);
    ackw(NIPC_ACK_VEC, 5'h02);
    pls(2);
    pls(1);
    ackw(NIPC_ACK_VEC, 5'h09);
    men = '0;
  endtask
  task automatic t_nmi;
    lv = '0;
    rs;
    pls(1);
    nmi = 1;
    ackw(NIPC_ACK_NMI, 5'h00);
    nmi = 0;
    chk("isr", 8'h40, isr);
    pls(1);
    raise(19'h00002);
    none;
    pls(2);
    pls(1);
    ackw(NIPC_ACK_VEC, 5'h01);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    t_nest;
    t_order;
    t_lvl3;
    t_macro;
    t_nmi;
    final_report;
  end
  // the whole run needs well under 1000 cycles
  initial begin
    #200000;
    errors++;
    final_report;
  end
endmodule
